// ### hdl/tqf_byte_ser.sv
// Purpose: Turns queue words into a byte stream towards the MAC
// Assumes: Load only while not busy
// Notes: Low byte goes out first
`timescale 1ns/1ps
`default_nettype none
module tqf_byte_ser (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [15:0] word,
	input wire logic twoBytes,
	input wire logic lastWord,
	output logic busy,
	output logic [7:0] macData,
	output logic macValid,
	output logic macLast,
	input wire logic macReady
);
	logic [7:0] data_reg;
	logic [7:0] hi_reg;
	logic hasHi_reg;
	logic last_reg;
	logic valid_reg;

	// ==========================================================
	// Byte holding
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			data_reg <= 8'h00;
			hi_reg <= 8'h00;
			hasHi_reg <= 1'b0;
			last_reg <= 1'b0;
			valid_reg <= 1'b0;
		end else if (load) begin
			data_reg <= word[7:0];
			hi_reg <= word[15:8];
			hasHi_reg <= twoBytes;
			last_reg <= lastWord;
			valid_reg <= 1'b1;
		end else if (valid_reg && macReady) begin
			if (hasHi_reg) begin
				data_reg <= hi_reg;
				hasHi_reg <= 1'b0;
			end else begin
				valid_reg <= 1'b0;
			end
		end
	end

	assign busy = valid_reg;
	assign macData = data_reg;
	assign macValid = valid_reg;
	assign macLast = valid_reg && last_reg && !hasHi_reg;
endmodule : tqf_byte_ser
`default_nettype wire

// ### hdl/tqf_queue_mem.sv
// Purpose: Transmit queue storage, 16-bit words
// Assumes: Simple dual port, registered read
// Notes: No reset on the array
`timescale 1ns/1ps
`default_nettype none
module tqf_queue_mem (
	input wire logic core_clk,
	tqf_mem_if.mem port
);
	logic [15:0] store [tqf_pkg::QUEUE_WORDS];
	logic [15:0] rdData_reg;

	// ==========================================================
	// Storage
	always_ff @(posedge core_clk) begin
		if (port.wrEn) begin
			store[port.wrAddr] <= port.wrData;
		end
		if (port.rdEn) begin
			rdData_reg <= store[port.rdAddr];
		end
	end

	assign port.rdData = rdData_reg;
endmodule : tqf_queue_mem
`default_nettype wire

// ### hdl/tqf_tx_queue.sv
// Purpose: Transmit queue frame descriptor handling, APB slave
// Assumes: Host writes each frame as control word, byte count, data
// Notes: Queue words are pushed one per write of the data register
//
// How it works
// - Control at 0, count at 2, data from 4
// - CRC appended by device only when enabled
// - Back to back frames sent in order
// - Status shows frame now going to MAC
// - Control bit 15 pulses completion interrupt
// - Bits 9-8 force ports 1 and 2
// - Both bits set send to both ports
// - Both bits clear use address lookup
// - Frame ident copied into transmit status
// - Length from bits 10-0 reclaims space
// - Source address sent unchanged
// - Length/type passed through as payload
// - Queue holds 4KB of frame memory
`timescale 1ns/1ps
`default_nettype none
module tqf_tx_queue (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [7:0] macData,
	output logic macValid,
	output logic macLast,
	input wire logic macReady,
	output logic [1:0] macDestPorts,
	output logic macLookup,
	output logic macAppendCrc,
	output logic txIrqPulse
);
	localparam int QA = tqf_pkg::QA_W;
	localparam int QP = tqf_pkg::QP_W;
	localparam int LM = tqf_pkg::FRAME_BYTE_LEN_MSB;

	typedef enum logic [1:0] {H_CTRL, H_LEN, H_DATA} tqf_host_t;
	typedef enum logic [2:0] {
		R_IDLE, R_CTRL, R_LEN, R_FETCH, R_LOAD, R_DRAIN, R_DONE
	} tqf_rd_t;

	tqf_mem_if memBus ();

	tqf_host_t host_reg;
	tqf_rd_t rd_reg;
	logic [1:0] ctrl_reg;
	logic [31:0] prdata_reg;
	logic [15:0] status_reg;
	logic [QP-1:0] wrPtr_reg;
	logic [QP-1:0] commitPtr_reg;
	logic [QP-1:0] reclaimPtr_reg;
	logic [QP-1:0] rdPtr_reg;
	logic [QP-1:0] wordsLeft_reg;
	logic [LM:0] frameLen_reg;
	logic [LM:0] bytesLeft_reg;
	logic irqReq_reg;
	logic [1:0] dest_reg;
	logic crc_reg;
	logic irq_reg;

	logic setup;
	logic access;
	logic addrOk;
	logic [QP-1:0] usedWords;
	logic qFull;
	logic push;
	logic pending;
	logic serBusy;
	logic serLoad;
	logic serTwo;
	logic serLast;
	logic [QP-1:0] lenWords;
	logic [LM:0] wrLen;

	// ==========================================================
	// Queue memory and byte stream
	tqf_queue_mem uMem (
		.core_clk(core_clk),
		.port(memBus)
	);

	tqf_byte_ser uSer (
		.core_clk(core_clk),
		.rst(rst),
		.load(serLoad),
		.word(memBus.rdData),
		.twoBytes(serTwo),
		.lastWord(serLast),
		.busy(serBusy),
		.macData(macData),
		.macValid(macValid),
		.macLast(macLast),
		.macReady(macReady)
	);

	// ==========================================================
	// APB decode
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign pready = access;
	assign addrOk = (paddr == tqf_pkg::REG_CTRL_OFS) ||
		(paddr == tqf_pkg::REG_QDATA_OFS) ||
		(paddr == tqf_pkg::REG_FREE_OFS) ||
		(paddr == tqf_pkg::REG_STATUS_OFS);
	assign usedWords = wrPtr_reg - reclaimPtr_reg;
	assign qFull = (usedWords == tqf_pkg::QUEUE_WORDS_P);
	assign push = access && pwrite && !qFull &&
		(paddr == tqf_pkg::REG_QDATA_OFS);
	assign pslverr = access && (!addrOk ||
		(pwrite && qFull && paddr == tqf_pkg::REG_QDATA_OFS));
	assign prdata = prdata_reg;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prdata_reg <= 32'h00000000;
		end else if (setup) begin
			unique case (paddr)
				tqf_pkg::REG_CTRL_OFS: prdata_reg <= {30'h0, ctrl_reg};
				tqf_pkg::REG_FREE_OFS:
					prdata_reg <= {19'h0,
						tqf_pkg::QUEUE_WORDS_P - usedWords, 1'b0};
				tqf_pkg::REG_STATUS_OFS:
					prdata_reg <= {16'h0, status_reg[15], host_reg != H_CTRL,
						status_reg[13:0]};
				default: prdata_reg <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= tqf_pkg::CTRL_RESET;
		end else if (access && pwrite && paddr == tqf_pkg::REG_CTRL_OFS) begin
			ctrl_reg <= pwdata[1:0];
		end
	end

	// ==========================================================
	// Host side: header and data words into the queue
	assign wrLen = pwdata[LM:0];
	assign memBus.wrEn = push;
	assign memBus.wrAddr = wrPtr_reg[QA-1:0];
	assign memBus.wrData = pwdata[15:0];

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wrPtr_reg <= '0;
		end else if (push) begin
			wrPtr_reg <= wrPtr_reg + 12'h001;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			host_reg <= H_CTRL;
			wordsLeft_reg <= '0;
			commitPtr_reg <= '0;
		end else if (push) begin
			unique case (host_reg)
				H_CTRL: host_reg <= H_LEN;
				H_LEN: begin
					wordsLeft_reg <= tqf_pkg::tqf_data_words(wrLen);
					if (wrLen == '0) begin
						host_reg <= H_CTRL;
						commitPtr_reg <= wrPtr_reg + 12'h001;
					end else begin
						host_reg <= H_DATA;
					end
				end
				H_DATA: begin
					wordsLeft_reg <= wordsLeft_reg - 12'h001;
					if (wordsLeft_reg == 12'h001) begin
						host_reg <= H_CTRL;
						commitPtr_reg <= wrPtr_reg + 12'h001;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Transmit side: parse header, stream frame, reclaim space
	assign pending = commitPtr_reg != reclaimPtr_reg;
	assign lenWords = tqf_pkg::tqf_data_words(frameLen_reg);
	assign serTwo = bytesLeft_reg > 11'h001;
	assign serLast = bytesLeft_reg <= 11'h002;
	assign serLoad = rd_reg == R_LOAD;

	always_comb begin
		memBus.rdEn = 1'b0;
		memBus.rdAddr = rdPtr_reg[QA-1:0];
		unique case (rd_reg)
			R_IDLE: begin
				memBus.rdEn = ctrl_reg[tqf_pkg::CTRL_TX_EN_BIT] && pending;
				memBus.rdAddr = reclaimPtr_reg[QA-1:0];
			end
			R_CTRL: memBus.rdEn = 1'b1;
			R_FETCH: memBus.rdEn = !serBusy;
			default: memBus.rdEn = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rd_reg <= R_IDLE;
			rdPtr_reg <= '0;
		end else begin
			unique case (rd_reg)
				R_IDLE: if (ctrl_reg[tqf_pkg::CTRL_TX_EN_BIT] && pending) begin
					rdPtr_reg <= reclaimPtr_reg + 12'h001;
					rd_reg <= R_CTRL;
				end
				R_CTRL: begin
					rdPtr_reg <= rdPtr_reg + 12'h001;
					rd_reg <= R_LEN;
				end
				R_LEN: rd_reg <= (memBus.rdData[LM:0] == '0) ? R_DONE : R_FETCH;
				R_FETCH: if (!serBusy) begin
					rdPtr_reg <= rdPtr_reg + 12'h001;
					rd_reg <= R_LOAD;
				end
				R_LOAD: rd_reg <= serLast ? R_DRAIN : R_FETCH;
				R_DRAIN: if (!serBusy) begin
					rd_reg <= R_DONE;
				end
				R_DONE: rd_reg <= R_IDLE;
				default: rd_reg <= R_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			frameLen_reg <= '0;
			bytesLeft_reg <= '0;
		end else if (rd_reg == R_LEN) begin
			frameLen_reg <= memBus.rdData[LM:0];
			bytesLeft_reg <= memBus.rdData[LM:0];
		end else if (serLoad) begin
			bytesLeft_reg <= serTwo ? bytesLeft_reg - 11'h002
				: bytesLeft_reg - 11'h001;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reclaimPtr_reg <= '0;
		end else if (rd_reg == R_DONE) begin
			reclaimPtr_reg <= reclaimPtr_reg + tqf_pkg::HDR_WORDS
				+ lenWords;
		end
	end

	// ==========================================================
	// Frame attributes, status and completion
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dest_reg <= 2'h0;
			irqReq_reg <= 1'b0;
			crc_reg <= 1'b0;
			status_reg <= tqf_pkg::STATUS_RESET;
		end else if (rd_reg == R_CTRL) begin
			dest_reg <= memBus.rdData[tqf_pkg::FORCED_DEST_MSB:
				tqf_pkg::FORCED_DEST_LSB];
			irqReq_reg <= memBus.rdData[tqf_pkg::IRQ_ON_COMPLETION_BIT];
			crc_reg <= ctrl_reg[tqf_pkg::CTRL_CRC_GEN_BIT];
			status_reg <= {1'b1, 5'h00,
				memBus.rdData[tqf_pkg::FORCED_DEST_MSB:
				tqf_pkg::FORCED_DEST_LSB], 2'h0,
				memBus.rdData[tqf_pkg::FRAME_IDENT_MSB:
				tqf_pkg::FRAME_IDENT_LSB]};
		end else if (rd_reg == R_DONE) begin
			status_reg[tqf_pkg::STAT_ACTIVE_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= (rd_reg == R_DONE) && irqReq_reg;
		end
	end

	assign macDestPorts = dest_reg;
	assign macLookup = dest_reg == 2'h0;
	assign macAppendCrc = crc_reg;
	assign txIrqPulse = irq_reg;
endmodule : tqf_tx_queue
`default_nettype wire

// ### inc/tqf_mem_if.sv
// Purpose: Port bundle between queue logic and the queue memory
// Assumes: One write port and one registered read port
// Notes: Read data is valid the cycle after rdEn
`timescale 1ns/1ps
`default_nettype none
interface tqf_mem_if;
	logic wrEn;
	logic [tqf_pkg::QA_W-1:0] wrAddr;
	logic [15:0] wrData;
	logic rdEn;
	logic [tqf_pkg::QA_W-1:0] rdAddr;
	logic [15:0] rdData;
	modport mem (input wrEn, wrAddr, wrData, rdEn, rdAddr, output rdData);
	modport user (output wrEn, wrAddr, wrData, rdEn, rdAddr, input rdData);
endinterface : tqf_mem_if
`default_nettype wire

// ### inc/tqf_pkg.sv
// Purpose: Constants and helpers for the transmit queue frame descriptor
// Assumes: 16-bit queue words, 4 KB transmit queue, APB register access
// Notes: Register offsets are byte addresses of aligned 32-bit words
package tqf_pkg;
	// ==========================================================
	// Queue geometry
	localparam int QUEUE_BYTES = 4096;
	localparam int QUEUE_WORDS = QUEUE_BYTES / 2;
	localparam int QA_W = 11;
	localparam int QP_W = 12;
	localparam logic [QP_W-1:0] QUEUE_WORDS_P = 12'h800;
	localparam logic [QP_W-1:0] HDR_WORDS = 12'h002;
	localparam int CTRL_WORD_OFS = 0;
	localparam int BYTE_LEN_OFS = 2;
	localparam int DATA_OFS = 4;
	localparam int MAX_DATA_BYTES = 1916;
	// ==========================================================
	// Control word and byte count fields
	localparam int IRQ_ON_COMPLETION_BIT = 15;
	localparam int FORCED_DEST_LSB = 8;
	localparam int FORCED_DEST_MSB = 9;
	localparam int FRAME_IDENT_LSB = 0;
	localparam int FRAME_IDENT_MSB = 5;
	localparam int FRAME_BYTE_LEN_MSB = 10;
	// ==========================================================
	// Register map
	localparam logic [7:0] REG_CTRL_OFS = 8'h00;
	localparam logic [7:0] REG_QDATA_OFS = 8'h04;
	localparam logic [7:0] REG_FREE_OFS = 8'h08;
	localparam logic [7:0] REG_STATUS_OFS = 8'h0C;
	localparam int CTRL_TX_EN_BIT = 0;
	localparam int CTRL_CRC_GEN_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam int STAT_DEST_LSB = 8;
	localparam int STAT_FILLING_BIT = 14;
	localparam int STAT_ACTIVE_BIT = 15;
	localparam logic [15:0] STATUS_RESET = 16'h0000;

	// Queue words taken by the data area of a frame
	function automatic logic [QP_W-1:0] tqf_data_words(
		input logic [FRAME_BYTE_LEN_MSB:0] len);
		logic [QP_W-1:0] sum;
		sum = {1'b0, len} + 12'h001;
		return {1'b0, sum[QP_W-1:1]};
	endfunction : tqf_data_words
endpackage : tqf_pkg

// ### tb/tqf_mac_sink.sv
// Purpose: MAC side byte sink with random stalls
// Assumes: Byte taken on valid and ready at an edge
// Notes: Own xorshift state, ready about three edges in four
`timescale 1ns/1ps
`default_nettype none
module tqf_mac_sink (
	output logic macReady,
	input wire logic core_clk,
	input wire logic rst
);
	// =====
	// Stall pattern
	logic [31:0] st;
	logic [31:0] a;
	logic [31:0] b;
	logic [31:0] stNext;
	assign a = st ^ (st << 13);
	assign b = a ^ (a >> 17);
	assign stNext = b ^ (b << 5);
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st <= 32'h3989009F;
			macReady <= 1'b0;
		end else begin
			st <= stNext;
			macReady <= stNext[1:0] != 2'h0;
		end
	end
endmodule : tqf_mac_sink
`default_nettype wire

// ### tb/tqf_tx_queue_monitor.sv
// Purpose: Port checker for the transmit queue
// Assumes: Zero wait state APB slave
// Notes: Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module tqf_tx_queue_monitor (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] macData,
	input wire logic macValid,
	input wire logic macLast,
	input wire logic macReady,
	input wire logic [1:0] macDestPorts,
	input wire logic macLookup,
	input wire logic macAppendCrc,
	input wire logic txIrqPulse
);
	// =====
	// Transmit enable as last written
	logic txEn;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) txEn <= 1'b0;
		else if (psel && penable && pwrite && paddr == 8'h00) txEn <= pwdata[0];
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// =====
	// Properties
	property p_rdy; psel && penable |-> pready; endproperty
	property p_idle; !(psel && penable) |-> !pready && !pslverr; endproperty
	property p_unmap;
		psel && penable && paddr > 8'h0C |-> pslverr && prdata == 32'h0;
	endproperty
	property p_ro;
		psel && penable && !pwrite && paddr == 8'h04 |-> prdata == 32'h0 && !pslverr;
	endproperty
	property p_hold;
		macValid && !macReady |=> macValid && $stable(macData) && $stable(macLast);
	endproperty
	property p_dest;
		macValid && !(macReady && macLast) |=>
			$stable(macDestPorts) && $stable(macAppendCrc);
	endproperty
	property p_look; macLookup == (macDestPorts == 2'h0); endproperty
	property p_irq; txIrqPulse |=> !txIrqPulse; endproperty
	property p_off; !txEn && !macValid |=> !macValid; endproperty
	property p_stat;
		psel && !penable && !pwrite && paddr == 8'h0C && macValid |=> prdata[15];
	endproperty
	a_rdy: assert property (p_rdy) else $error("pready missing in access");
	a_idle: assert property (p_idle) else $error("pready outside access");
	a_unmap: assert property (p_unmap) else $error("unmapped not refused");
	a_ro: assert property (p_ro) else $error("data port read not zero");
	a_hold: assert property (p_hold) else $error("byte dropped");
	a_dest: assert property (p_dest) else $error("dest moved");
	a_look: assert property (p_look) else $error("lookup wrong");
	a_irq: assert property (p_irq) else $error("irq too long");
	a_off: assert property (p_off) else $error("sent while off");
	a_stat: assert property (p_stat) else $error("status not active");
	c_last: cover property (macValid && macReady && macLast);
	c_irq: cover property (txIrqPulse);
	c_err: cover property (psel && penable && pslverr);
	c_stat: cover property (psel && penable && paddr == 8'h0C && prdata[15]);
endmodule : tqf_tx_queue_monitor
bind tqf_tx_queue tqf_tx_queue_monitor i_mon (.core_clk, .rst, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .macData, .macValid,
	.macLast, .macReady, .macDestPorts, .macLookup, .macAppendCrc, .txIrqPulse);
`default_nettype wire

// ### tb/tqf_tx_queue_tb_top.sv
// Purpose: Self-checking bench for the transmit queue
// Assumes: Zero wait state APB, MAC sink stalls at random
// Notes: Expected bytes and frame fields kept in queues
`timescale 1ns/1ps
`default_nettype none
module tqf_tx_queue_tb_top;
	logic core_clk, rst, psel, penable, pwrite, macReady;
	logic pready, pslverr, macValid, macLast, macLookup;
	logic macAppendCrc, txIrqPulse, rerr, crcOn, fullSeen, first;
	logic [7:0] paddr, macData;
	logic [1:0] macDestPorts;
	logic [15:0] lastCtl;
	logic [31:0] pwdata, prdata, rdat, seed;
	int n_errors, comparisons, cyc, irqs, expIrq, b, m;
	int expB[$];
	int expM[$];
	tqf_tx_queue i_dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .macData, .macValid, .macLast,
		.macReady, .macDestPorts, .macLookup, .macAppendCrc, .txIrqPulse);
	tqf_mac_sink i_sink (.core_clk, .rst, .macReady);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// =====
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic check(input string s, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", s, exp, seen);
		end
	endtask : check
	task automatic wrap_up();
		if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb
	// Full queue: enable sending, then retry the dropped word
	task automatic push(input logic [15:0] w);
		logic [31:0] r;
		logic e;
		do begin
			r = rnd();
			apb(1'b1, 8'h04, {r[31:16], w});
			e = rerr;
			if (e && !fullSeen) begin
				fullSeen = 1'b1;
				apb(1'b0, 8'h08, 32'h0);
				check("free_full", rdat, 32'h0);
				apb(1'b1, 8'h00, {30'h0, crcOn, 1'b1});
			end
		end while (e);
	endtask : push
	task automatic send_frame(input logic [15:0] ctl, input int len);
		logic [31:0] r;
		lastCtl = ctl;
		expIrq += ctl[15];
		expM.push_back({crcOn, ctl[9:8]});
		push(ctl);
		push({5'h00, len[10:0]});
		for (int i = 0; i < len; i += 2) begin
			r = rnd();
			push(r[15:0]);
			expB.push_back({(i + 1 == len), r[7:0]});
			if (i + 1 < len) expB.push_back({(i + 2 == len), r[15:8]});
		end
	endtask : send_frame
	task automatic drain();
		rdat = 32'h0;
		for (int i = 0; i < 5000 && rdat !== 32'h1000; i++) begin
			apb(1'b0, 8'h0C, 32'h0);
			apb(1'b0, 8'h08, 32'h0);
		end
		check("drained", expB.size(), 0);
		check("free", rdat, 32'h1000);
		apb(1'b0, 8'h0C, 32'h0);
		check("status", rdat & 32'hC33F,
			{22'h0, lastCtl[9:8], 2'h0, lastCtl[5:0]});
	endtask : drain
	// =====
	// Byte stream model
	always @(posedge core_clk) begin
		cyc++;
		if (txIrqPulse === 1'b1) irqs++;
		if (!rst && macValid === 1'b1 && macReady === 1'b1) begin
			if (first) begin
				m = expM.pop_front();
				check("dest", macDestPorts, m[1:0]);
				check("lookup", macLookup, m[1:0] == 2'h0);
				check("crc", macAppendCrc, m[2]);
			end
			b = expB.pop_front();
			check("byte", {macLast, macData}, b[8:0]);
			first = b[8];
		end
		if (cyc == 80000) begin
			n_errors++;
			wrap_up();
		end
	end
	// =====
	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		rst = 1'b1;
		seed = 32'h3989009F;
		{first, crcOn, fullSeen, lastCtl} = {2'h3, 17'h0};
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		apb(1'b0, 8'h00, 32'h0);
		check("ctrl", rdat, 32'h0);
		apb(1'b0, 8'h0C, 32'h0);
		check("status0", rdat, 32'h0);
		apb(1'b1, 8'h08, 32'h0);
		apb(1'b0, 8'h04, 32'h0);
		check("qdata", rdat, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		check("unmapped", rerr, 1'b1);
		apb(1'b0, 8'h08, 32'h0);
		check("free0", rdat, 32'h1000);
		for (int k = 0; k < 4; k++)
			send_frame({1'b1, 5'h00, 2'(k), 2'h0, 6'(k + 32)}, 1916);
		check("refused", fullSeen, 1'b1);
		drain();
		crcOn = 1'b0;
		apb(1'b1, 8'h00, 32'h1);
		for (int k = 0; k < 12; k++)
			send_frame(16'(rnd()) & 16'h803F | 16'((k % 4) << 8),
				int'(rnd() % 40) + 1);
		drain();
		check("irqs", irqs, expIrq);
		wrap_up();
	end
endmodule : tqf_tx_queue_tb_top
`default_nettype wire
